// >>> core/pes_pull_edit_sequencer.sv
// Purpose: Pull-type edit sequencer for the display buffer in core memory
// Assumes: Memory answers within each phase; one edit at a time
// Notes: Registers over AXI4-Lite; phases counted one per enabled clock
//
// Functional notes
// - Four-clock gap after first edit cycle
// - Gap copies cursor, then cursor leads one
// - Read stage raises request, selects cursor addressing
// - Read stage rewrites character, keeps for display
// - Cursor counts up at phase four
// - Phase five: read stage off, write stage on
// - Late phase five loads display register
// - Memory-addressed cycle writes display register contents
// - Memory counter counts up at phase four
// - Phase five returns to read stage
// - End symbol sets last-cycle flag, one more
// - Final cycle presets put counter, starts display
// - Final phase five ends request, clears flag
// - Preset put does tab only, then clears
// - Get stage pulse bumps restored cursor
// - Stage pulse sets pending, clears release hold
// - Next put stores corrected cursor normally
// - Pending pulse frees keyboards and load flag
// - Delete copies cursor first, cursor leads
// - Delete only when cursor over data
// - First replace cycle clears start, bumps cursor
// - Release hold blocks busy clear until cleared
`timescale 1ns/100ps
`default_nettype none
module pes_pull_edit_sequencer
  import pes_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned CW = CHAR_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Core memory
  output logic [AW-1:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic [CW-1:0] mem_wdata,
  input wire logic [CW-1:0] mem_rdata,
  // Display and keyboard side
  input wire logic monitor_get_slot,
  input wire logic cursor_over_data,
  input wire logic [AW-1:0] restored_cursor,
  output logic display_start,
  output logic put_cycle_five_preset,
  output logic keyboard_busy_flag,
  output logic keyboard_release_hold,
  output logic put_store_cursor
);

  typedef struct packed {
    pes_state_e st;
    logic [2:0] phase;
    logic [2:0] gap;
    logic pull_read_stage;
    logic pull_write_stage;
    logic edit_cycle_active;
    logic last_cycle_flag;
    logic replace_one_start;
    logic first_cycle;
    logic [AW-1:0] cursor_count;
    logic [AW-1:0] memory_addr_count;
    logic [CW-1:0] memory_info_register;
    logic [CW-1:0] display_reg;
    logic put_preset;
    logic second_get_pending;
    logic release_hold;
    logic busy;
    logic load_flag;
    logic disp_start;
    logic put_store;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pes_state_s;

  pes_state_s state_reg;
  pes_state_s state_next;
  logic edit_memory_request;
  logic cursor_addr_select;
  logic memory_addr_select;
  logic get_stage_pulse;
  logic wr_fire;
  logic [CW-1:0] kbd_char;

  ////////////////////////////////////////////////////////////////////
  // Request and address selection
  assign edit_memory_request = state_reg.pull_read_stage | state_reg.pull_write_stage;
  assign cursor_addr_select = state_reg.edit_cycle_active & ~state_reg.pull_write_stage;
  assign memory_addr_select = state_reg.pull_write_stage;
  assign get_stage_pulse = monitor_get_slot & state_reg.load_flag;
  assign wr_fire = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
  assign kbd_char = state_reg.wdata[8+CW-1:8];

  // Memory strobes: phases 0-1 read, 2-3 write
  assign mem_addr = memory_addr_select ? state_reg.memory_addr_count : state_reg.cursor_count;
  assign mem_read = (state_reg.st == ST_CYCLE) && (state_reg.phase < 3'd2);
  assign mem_write = (state_reg.st == ST_CYCLE) && (state_reg.phase == 3'd2 ||
                     state_reg.phase == 3'd3);
  assign mem_wdata = state_reg.pull_read_stage ? state_reg.memory_info_register :
                     state_reg.display_reg;

  assign display_start = state_reg.disp_start;
  assign put_cycle_five_preset = state_reg.put_preset;
  assign keyboard_busy_flag = state_reg.busy;
  assign keyboard_release_hold = state_reg.release_hold;
  assign put_store_cursor = state_reg.put_store;

  assign s_awready = ~state_reg.aw_got;
  assign s_wready = ~state_reg.w_got;
  assign s_bvalid = state_reg.bvalid;
  assign s_bresp = state_reg.bresp;
  assign s_arready = ~state_reg.rvalid;
  assign s_rvalid = state_reg.rvalid;
  assign s_rresp = state_reg.rresp;
  assign s_rdata = state_reg.rdata;

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.disp_start = 1'b0;
    state_next.put_store = 1'b0;
    // Get handling first, so an edit start in the same cycle wins over it
    if (get_stage_pulse && state_reg.st == ST_IDLE) begin
      if (state_reg.second_get_pending && !state_reg.release_hold) begin
        state_next.busy = 1'b0;
        state_next.load_flag = 1'b0;
        state_next.second_get_pending = 1'b0;
        state_next.cursor_count = restored_cursor;
      end else begin
        state_next.cursor_count = restored_cursor + {{(AW-1){1'b0}}, 1'b1};
        state_next.second_get_pending = 1'b1;
        state_next.release_hold = 1'b0;
      end
    end
    // Write channel capture
    if (s_awvalid && s_awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_wdata;
    end
    if (state_reg.bvalid && s_bready) begin
      state_next.bvalid = 1'b0;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
    end
    if (wr_fire) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (state_reg.awaddr == OFF_CTRL) begin
        if (s_wstrb[0]) begin
          // Starts are honoured only while idle, keeping edits serialised
          if (state_reg.wdata[CTRL_REPLACE] && state_reg.st == ST_IDLE) begin
            state_next.replace_one_start = 1'b1;
            state_next.pull_read_stage = 1'b0;
            state_next.edit_cycle_active = 1'b1;
            state_next.first_cycle = 1'b1;
            state_next.display_reg = kbd_char;
            state_next.release_hold = 1'b1;
            state_next.busy = 1'b1;
            state_next.load_flag = 1'b1;
            state_next.st = ST_CYCLE;
            state_next.phase = 3'd0;
          end else if (state_reg.wdata[CTRL_DELETE] && state_reg.st == ST_IDLE &&
                       cursor_over_data) begin
            state_next.memory_addr_count = state_reg.cursor_count;
            state_next.cursor_count = state_reg.cursor_count + {{(AW-1){1'b0}}, 1'b1};
            state_next.pull_read_stage = 1'b1;
            state_next.edit_cycle_active = 1'b1;
            state_next.release_hold = 1'b1;
            state_next.busy = 1'b1;
            state_next.load_flag = 1'b1;
            state_next.st = ST_CYCLE;
            state_next.phase = 3'd0;
          end
          if (state_reg.wdata[CTRL_PUT]) begin
            if (state_reg.put_preset) begin
              state_next.put_preset = 1'b0;
            end else begin
              state_next.put_store = 1'b1;
            end
          end
        end
      end else if (state_reg.awaddr == OFF_CURSOR && state_reg.st == ST_IDLE) begin
        if (s_wstrb[0]) begin
          state_next.cursor_count[7:0] = state_reg.wdata[7:0];
        end
        if (s_wstrb[1]) begin
          state_next.cursor_count[AW-1:8] = state_reg.wdata[AW-1:8];
        end
      end else if (state_reg.awaddr != OFF_STATUS && state_reg.awaddr != OFF_MEMADDR &&
                   state_reg.awaddr != OFF_DISPLAY) begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    // Read channel
    if (state_reg.rvalid && s_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      case (s_araddr)
        OFF_STATUS: state_next.rdata = {22'h0, state_reg.put_preset,
                                        state_reg.second_get_pending, state_reg.release_hold,
                                        state_reg.busy, state_reg.last_cycle_flag,
                                        state_reg.pull_write_stage, state_reg.pull_read_stage,
                                        state_reg.st};
        OFF_CURSOR: state_next.rdata = {{(32-AW){1'b0}}, state_reg.cursor_count};
        OFF_MEMADDR: state_next.rdata = {{(32-AW){1'b0}}, state_reg.memory_addr_count};
        OFF_DISPLAY: state_next.rdata = {{(32-CW){1'b0}}, state_reg.display_reg};
        OFF_CTRL: state_next.rdata = 32'h0;
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Edit sequencing
    case (state_reg.st)
      ST_IDLE: begin
        state_next.phase = 3'd0;
      end
      ST_CYCLE: begin
        state_next.phase = state_reg.phase + 3'd1;
        if (state_reg.phase == 3'd1 && state_reg.pull_read_stage) begin
          state_next.memory_info_register = mem_rdata;
        end
        if (state_reg.phase == 3'd3) begin
          if (cursor_addr_select) begin
            state_next.cursor_count = state_reg.cursor_count + {{(AW-1){1'b0}}, 1'b1};
            if (state_reg.pull_read_stage && state_reg.memory_info_register == END_SYMBOL) begin
              state_next.last_cycle_flag = 1'b1;
            end
          end else begin
            state_next.memory_addr_count = state_reg.memory_addr_count +
                                           {{(AW-1){1'b0}}, 1'b1};
            if (state_reg.last_cycle_flag) begin
              state_next.put_preset = 1'b1;
              state_next.disp_start = 1'b1;
            end
          end
        end
        if (state_reg.phase == 3'(PHASES - 1)) begin
          state_next.phase = 3'd0;
          if (state_reg.first_cycle) begin
            state_next.replace_one_start = 1'b0;
            state_next.first_cycle = 1'b0;
            state_next.st = ST_GAP;
            state_next.gap = 3'd0;
          end else if (state_reg.pull_read_stage) begin
            state_next.pull_read_stage = 1'b0;
            state_next.pull_write_stage = 1'b1;
            state_next.display_reg = state_reg.memory_info_register;
          end else if (state_reg.last_cycle_flag) begin
            state_next.pull_write_stage = 1'b0;
            state_next.last_cycle_flag = 1'b0;
            state_next.edit_cycle_active = 1'b0;
            state_next.st = ST_DONE;
          end else begin
            state_next.pull_read_stage = 1'b1;
            state_next.pull_write_stage = 1'b0;
          end
        end
      end
      ST_GAP: begin
        state_next.gap = state_reg.gap + 3'd1;
        if (state_reg.gap == 3'd0) begin
          state_next.memory_addr_count = state_reg.cursor_count;
        end
        if (state_reg.gap == 3'd1) begin
          state_next.cursor_count = state_reg.cursor_count + {{(AW-1){1'b0}}, 1'b1};
        end
        if (state_reg.gap == 3'(GAP_CLOCKS - 1)) begin
          state_next.pull_read_stage = 1'b1;
          state_next.st = ST_CYCLE;
        end
      end
      ST_DONE: begin
        state_next.st = ST_IDLE;
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_first_end;
    state_reg.st == ST_CYCLE && state_reg.phase == 3'd4 && state_reg.first_cycle;
  endsequence

  a_gap_four: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && $rose(state_reg.st == ST_GAP)) |-> (state_reg.st == ST_GAP) [*4]
      ##1 (state_reg.st == ST_CYCLE || !clk_en))
    else $error("gap not four clocks");
  a_cursor_leads: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg.st == ST_GAP && state_reg.gap == 3'd3 && clk_en) |=>
      state_reg.cursor_count == state_reg.memory_addr_count + 10'h1)
    else $error("cursor does not lead by one");
  a_req_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.pull_read_stage |-> edit_memory_request && !memory_addr_select)
    else $error("read stage without request");
  a_write_select: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.pull_write_stage |-> memory_addr_select &&
      mem_addr == state_reg.memory_addr_count)
    else $error("write stage not memory addressed");
  a_stage_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(state_reg.pull_read_stage && state_reg.pull_write_stage))
    else $error("both stages set");
  a_display_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && state_reg.st == ST_CYCLE && state_reg.phase == 3'd4 &&
     state_reg.pull_read_stage && !state_reg.first_cycle) |=>
      state_reg.display_reg == $past(state_reg.memory_info_register))
    else $error("display register not loaded");
  a_last_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && state_reg.last_cycle_flag && state_reg.pull_write_stage &&
     state_reg.phase == 3'd4) |=> !edit_memory_request && !state_reg.last_cycle_flag)
    else $error("final cycle did not end");
  a_first_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_first_end and clk_en) |=> !state_reg.replace_one_start)
    else $error("replace start not cleared");
  a_hold_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg.release_hold |=> state_reg.busy || !state_reg.release_hold)
    else $error("busy cleared under hold");
endmodule : pes_pull_edit_sequencer
`default_nettype wire

// >>> shared/pes_pkg.sv
// Purpose: Constants and types for the pull edit sequencer
// Assumes: 100 MHz aclk, ten-bit core address, six-bit characters
// Notes: AXI4-Lite register map of the sequencer
`default_nettype none
package pes_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned GAP_CLOCKS = 4;
  localparam int unsigned PHASES = 5;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CHAR_W = 6;
  localparam logic [5:0] END_SYMBOL = 6'h3f;
  localparam logic [2:0] PUT_FIVE = 3'h4;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CURSOR = 8'h08;
  localparam logic [7:0] OFF_MEMADDR = 8'h0c;
  localparam logic [7:0] OFF_DISPLAY = 8'h10;
  // Control bit positions (write one to start; CTRL_GET is never decoded, gets come from monitor_get_slot)
  localparam int unsigned CTRL_REPLACE = 0;
  localparam int unsigned CTRL_DELETE = 1;
  localparam int unsigned CTRL_GET = 2;
  localparam int unsigned CTRL_PUT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CYCLE = 3'b001,
    ST_GAP = 3'b010,
    ST_DONE = 3'b011
  } pes_state_e;
endpackage : pes_pkg
`default_nettype wire

// >>> verif/pes_core_mem_model.sv
// Purpose: Behavioural core memory facing the pull edit sequencer
// Assumes: Read data valid while mem_read is high, writes land on each write edge
// Notes: Released data lines show the inverse of the last read value
`timescale 1ns/100ps
`default_nettype none
module pes_core_mem_model
  import pes_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Memory port
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [CHAR_W-1:0] mem_wdata,
  output logic [CHAR_W-1:0] mem_rdata
);
  logic [CHAR_W-1:0] cells [0:(1 << ADDR_W)-1];
  logic [CHAR_W-1:0] last_q = 6'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Clear store so unloaded places read as a known space
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      cells[i] = 6'h00;
    end
  end

  // Write phases store the inhibit data; read phases remember the last word
  always @(posedge aclk) begin
    if (mem_write === 1'b1) cells[mem_addr] <= mem_wdata;
    if (mem_read === 1'b1) last_q <= cells[mem_addr];
  end

  // Inverse when released, so a late sample cannot pass by luck
  assign mem_rdata = (mem_read === 1'b1) ? cells[mem_addr] : ~last_q;
endmodule : pes_core_mem_model
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the pull edit sequencer
// Assumes: clk_en high except one frozen get, full word strobes, one get pulse per slot
// Notes: Expected read results queue up and a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pes_pkg::*;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} pes_exp_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] restored_cursor = 10'h000;
  logic mem_read, mem_write, display_start, put_cycle_five_preset;
  logic keyboard_busy_flag, keyboard_release_hold, put_store_cursor;
  logic [CHAR_W-1:0] mem_wdata, mem_rdata, kb, c1, c2, d0, d1, d2;
  logic monitor_get_slot = 1'b0, cursor_over_data = 1'b0, meas = 1'b0, seen_w = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] got;
  pes_exp_s rq[$];
  logic [1:0] bq[$];
  int runs[$];
  int run = 0, starts = 0, stores = 0, mismatches = 0, num_checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #5 aclk = ~aclk;

  pes_pull_edit_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .monitor_get_slot(monitor_get_slot),
    .cursor_over_data(cursor_over_data), .restored_cursor(restored_cursor),
    .display_start(display_start), .put_cycle_five_preset(put_cycle_five_preset),
    .keyboard_busy_flag(keyboard_busy_flag), .keyboard_release_hold(keyboard_release_hold),
    .put_store_cursor(put_store_cursor));

  pes_core_mem_model u_mem (.aclk(aclk), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_write(mem_write), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report tasks
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
    check_val({30'h0, g}, {30'h0, e});
  endtask : check_resp

  task automatic final_report();
    if (mismatches == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite master; ready sampled between edges, released on the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_p, w_p, aw_ok, w_ok;
    aw_p = 1'b1;
    w_p = 1'b1;
    bq.push_back(r);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge aclk);
      aw_ok = aw_p && (s_awready === 1'b1);
      w_ok = w_p && (s_wready === 1'b1);
      @(posedge aclk);
      if (aw_ok) s_awvalid <= 1'b0;
      if (aw_ok) aw_p = 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
      if (w_ok) w_p = 1'b0;
    end
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input logic [1:0] r);
    rq.push_back('{e, m, r});
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    got = s_rdata;
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask : axi_read

  // Poll status until the sequencer reports idle
  task automatic wait_idle();
    do axi_read(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY); while (got[2:0] !== 3'h0);
  endtask : wait_idle

  // One get slot for this monitor with the restored cursor on its lines
  task automatic get_pulse(input logic [ADDR_W-1:0] c);
    @(posedge aclk);
    restored_cursor <= c;
    monitor_get_slot <= 1'b1;
    @(posedge aclk);
    monitor_get_slot <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : get_pulse

  ////////////////////////////////////////////////////////////////////////////////
  // Response monitor: oldest note against each answer
  always @(posedge aclk) begin
    pes_exp_s e;
    if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
      e = rq.pop_front();
      check_val(s_rdata & e.mask, e.data & e.mask);
      check_resp(s_rresp, e.resp);
    end
    if (s_bvalid === 1'b1 && s_bready === 1'b1) check_resp(s_bresp, bq.pop_front());
  end

  // Pulse counters and idle-run lengths between memory cycles
  always @(posedge aclk) begin
    if (display_start === 1'b1) starts++;
    if (put_store_cursor === 1'b1) stores++;
    if (meas && mem_write === 1'b1) seen_w = 1'b1;
    if (meas && seen_w && mem_read !== 1'b1 && mem_write !== 1'b1) run++;
    else if (run > 0) begin
      runs.push_back(run);
      run = 0;
    end
  end

  // Watchdog; the whole run needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    got = $urandom(32'hf82e44e5);
    kb = 6'($urandom_range(62, 1));
    c1 = 6'($urandom_range(62, 1));
    c2 = 6'($urandom_range(62, 1));
    d0 = 6'($urandom_range(62, 1));
    d1 = 6'($urandom_range(62, 1));
    d2 = 6'($urandom_range(62, 1));
    #1;
    u_mem.cells[11] = 6'h3e;
    u_mem.cells[12] = c1;
    u_mem.cells[13] = c2;
    u_mem.cells[14] = END_SYMBOL;
    u_mem.cells[40] = d0;
    u_mem.cells[41] = d1;
    u_mem.cells[42] = d2;
    u_mem.cells[43] = END_SYMBOL;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state and an unmapped place
    axi_read(OFF_STATUS, 32'h0, 32'hffffffff, RESP_OKAY);
    check_val({31'h0, keyboard_busy_flag}, 32'h0);
    axi_read(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    axi_write(8'h20, 32'h0, RESP_SLVERR);
    // Pull-by-one replace at cursor ten
    axi_write(OFF_CURSOR, 32'd10, RESP_OKAY);
    axi_read(OFF_CURSOR, 32'd10, 32'h3ff, RESP_OKAY);
    meas <= 1'b1;
    axi_write(OFF_CTRL, {18'h0, kb, 8'h01}, RESP_OKAY);
    check_val({31'h0, keyboard_release_hold}, 32'h1);
    wait_idle();
    meas <= 1'b0;
    check_val(runs[0], 32'd5);
    check_val(runs[1], 32'd1);
    check_val(u_mem.cells[10], kb);
    check_val(u_mem.cells[11], c1);
    check_val(u_mem.cells[12], c2);
    check_val(u_mem.cells[13], END_SYMBOL);
    check_val(u_mem.cells[14], END_SYMBOL);
    axi_read(OFF_CURSOR, 32'd15, 32'h3ff, RESP_OKAY);
    axi_read(OFF_MEMADDR, 32'd14, 32'h3ff, RESP_OKAY);
    axi_read(OFF_DISPLAY, {26'h0, END_SYMBOL}, 32'h3f, RESP_OKAY);
    check_val(starts, 32'd1);
    check_val({31'h0, put_cycle_five_preset}, 32'h1);
    check_val({31'h0, keyboard_busy_flag}, 32'h1);
    // Inhibited put, then the two gets
    axi_write(OFF_CTRL, 32'h8, RESP_OKAY);
    check_val({31'h0, put_cycle_five_preset}, 32'h0);
    check_val(stores, 32'd0);
    get_pulse(10'd10);
    axi_read(OFF_CURSOR, 32'd11, 32'h3ff, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h100, 32'h100, RESP_OKAY);
    check_val({31'h0, keyboard_release_hold}, 32'h0);
    check_val({31'h0, keyboard_busy_flag}, 32'h1);
    axi_write(OFF_CTRL, 32'h8, RESP_OKAY);
    // Let the pulse counter see the store edge first
    @(negedge aclk);
    check_val(stores, 32'd1);
    get_pulse(10'd10);
    check_val({31'h0, keyboard_busy_flag}, 32'h0);
    // Delete refused off data, then accepted
    axi_write(OFF_CURSOR, 32'd40, RESP_OKAY);
    axi_write(OFF_CTRL, 32'h2, RESP_OKAY);
    axi_read(OFF_STATUS, 32'h0, 32'h7, RESP_OKAY);
    check_val(u_mem.cells[40], d0);
    cursor_over_data <= 1'b1;
    axi_write(OFF_CTRL, 32'h2, RESP_OKAY);
    wait_idle();
    check_val(u_mem.cells[40], d1);
    check_val(u_mem.cells[41], d2);
    check_val(u_mem.cells[42], END_SYMBOL);
    axi_read(OFF_MEMADDR, 32'd43, 32'h3ff, RESP_OKAY);
    // Frozen clock enable must ignore a get slot; cursor stays one ahead
    clk_en <= 1'b0;
    get_pulse(10'd20);
    clk_en <= 1'b1;
    axi_read(OFF_CURSOR, 32'd44, 32'h3ff, RESP_OKAY);
    final_report();
  end
endmodule : testbench
`default_nettype wire
